// File: inc/wdpd_defs.vh
// Constants for the watchdog and power-down control block.
// Assumes inclusion by bare name from the design files.
`ifndef WDPD_DEFS_VH
`define WDPD_DEFS_VH

// Register addresses on the on-chip I/O port
`define WDPD_ADDR_MASTER 8'hf0
`define WDPD_ADDR_CMD 8'hf1
`define WDPD_ADDR_MISC 8'hf2

// Command register keys
`define WDPD_KEY_DISABLE 8'hb1
`define WDPD_KEY_HALT_MODE_FIELD 8'hdb
`define WDPD_KEY_CLEAR 8'h4e

// Master register fields
`define WDPD_BIT_EN 7
`define WDPD_PER_HI 6
`define WDPD_PER_LO 5
`define WDPD_HALT_MODE_FIELD_HI 4
`define WDPD_HALT_MODE_FIELD_LO 3

// Halt mode encodings
`define WDPD_HALT_MODE_FIELD_RUN 2'b11
`define WDPD_HALT_MODE_FIELD_FIRST_IDLE_MODE 2'b00
`define WDPD_HALT_MODE_FIELD_SECOND_IDLE_MODE 2'b01
`define WDPD_HALT_MODE_FIELD_STOP 2'b10

// Misc register fields and reset value
`define WDPD_BIT_RSTOUT_DIS 3
`define WDPD_BIT_CRC32 2
`define WDPD_BIT_CS1_EN 1
`define WDPD_BIT_CS0_EN 0
`define WDPD_MISC_RESET 8'h01

// Master reset value: enabled, longest period, run mode
`define WDPD_MASTER_RESET 8'hf8

// Pulse lengths in system clock cycles
`define WDPD_TIMEOUT_PULSE 5
`define WDPD_RSTOUT_CYCLES 16

// Period codes 0..2 drop this many top counter bits
`define WDPD_PER0_SHIFT 8
`define WDPD_PER1_SHIFT 6
`define WDPD_PER2_SHIFT 4

`endif

// File: hw/wdpd_sync2.v
// Two flip-flop synchroniser for a single level.
// Assumes the input is asynchronous to i_core_clk.
`timescale 1ns/100ps
module wdpd_sync2 #(
	parameter RESET_VAL = 1'b0
)
(
	input wire i_core_clk, // System clock
	input wire i_rst, // Async reset, active high
	input wire i_async, // Raw level
	output wire o_sync // Synchronised level
);
	reg meta_q;
	reg sync_q;

	// Second stage only reads the first
	always @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			meta_q <= RESET_VAL;
			sync_q <= RESET_VAL;
		end
		else
		begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;
endmodule

// File: hw/wdpd_top.v
// Watchdog, halt power-down and chip-select control on the on-chip I/O port.
// Assumes I/O strobes come from processor logic on i_core_clk; pins are synced.
`timescale 1ns/100ps
`include "wdpd_defs.vh"
module wdpd_top #(
	parameter CNT_W = 24, // Watchdog counter width
	parameter [1:0] CS_W = 2'd0 // Unused spare
)
(
	input wire i_core_clk, // System clock
	input wire i_rst, // Power-on reset, async, active high
	input wire i_io_wr, // I/O write strobe, one cycle
	input wire i_io_rd, // I/O read strobe, one cycle
	input wire [7:0] i_io_addr, // I/O address
	input wire [7:0] i_io_wdata, // I/O write data
	output reg [7:0] o_io_rdata, // I/O read data, registered
	input wire i_halt_t4, // Halt fetch reached T4 low, one cycle
	input wire i_nop_t4, // Restart NOP at T4 low, one cycle
	input wire i_int_ack, // Interrupt accepted at NOP T4
	input wire i_reset_n_pin, // Reset input pin, active low
	input wire i_nmi_n_pin, // NMI pin, active low
	input wire i_int_n_pin, // INT pin, active low
	input wire i_tout_to_reset, // Strap: timeout wired to reset
	input wire i_clk_from_gen, // Strap: system clock fed by generator
	input wire i_osc_in, // Oscillator input level
	input wire [15:12] i_addr_hi, // Upper address bits
	input wire [3:0] i_cs0_base, // First chip-select range start
	input wire [3:0] i_cs0_limit, // First chip-select range end
	input wire [3:0] i_cs1_base, // Second chip-select range start
	input wire [3:0] i_cs1_limit, // Second chip-select range end
	output reg o_timeout_output_n, // Watchdog timeout, active low
	output reg o_reset_out_n, // Reset drive out, active low
	output reg o_reset_out_oe, // Reset drive enable
	output reg o_generator_clock_output, // Divided clock output
	output reg o_osc_run, // Oscillator enable
	output reg o_cpu_clk_en, // CPU, parallel, serial clock gate
	output reg o_ctr_clk_en, // Counter unit clock gate
	output reg o_crc32_sel, // Serial channel A CRC select
	output reg o_chip_select_first_n, // First chip select, active low
	output reg o_chip_select_second_n // Second chip select, active low
);
	localparam [1:0] ST_RUN = 2'd0;
	localparam [1:0] ST_HALT = 2'd1;
	localparam [1:0] ST_STOPPED = 2'd2;
	localparam [1:0] ST_NOP = 2'd3;

	reg [7:0] master_q, misc_q;
	reg key_halt_q, disarm_q, rst_n_prev_q, div_q;
	reg [1:0] st_q, st_d;
	reg [CNT_W-1:0] cnt_q, limit;
	reg [2:0] pulse_q;
	reg [4:0] rst_cnt_q;
	wire rst_n_s, nmi_n_s, int_n_s, osc_s;
	wire wdt_en, wr_master, wr_cmd, wr_misc, wake, clocks_off, expire, tout_active;
	wire [1:0] halt_mode;

	// Range decode on top nibble, no strobes
	function cs_hit;
		input [3:0] a;
		input [3:0] lo;
		input [3:0] hi;
		begin
			cs_hit = (a >= lo) && (a <= hi);
		end
	endfunction

	// Pin synchronisers
	wdpd_sync2 #(.RESET_VAL(1'b1)) u_rst (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_async(i_reset_n_pin), .o_sync(rst_n_s));
	wdpd_sync2 #(.RESET_VAL(1'b1)) u_nmi (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_async(i_nmi_n_pin), .o_sync(nmi_n_s));
	wdpd_sync2 #(.RESET_VAL(1'b1)) u_int (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_async(i_int_n_pin), .o_sync(int_n_s));
	wdpd_sync2 #(.RESET_VAL(1'b0)) u_osc (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_async(i_osc_in), .o_sync(osc_s));

	// Register decode
	assign wr_master = i_io_wr && (i_io_addr == `WDPD_ADDR_MASTER);
	assign wr_cmd = i_io_wr && (i_io_addr == `WDPD_ADDR_CMD);
	assign wr_misc = i_io_wr && (i_io_addr == `WDPD_ADDR_MISC);
	assign wdt_en = master_q[`WDPD_BIT_EN];
	assign halt_mode = master_q[`WDPD_HALT_MODE_FIELD_HI:`WDPD_HALT_MODE_FIELD_LO];
	assign wake = ~rst_n_s | ~nmi_n_s | ~int_n_s;

	// Master register with double keys
	always @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			master_q <= `WDPD_MASTER_RESET;
			key_halt_q <= 1'b0;
			disarm_q <= 1'b0;
		end
		else
		begin
			if (wr_master)
			begin
				// Period always writable; enable only sets here
				master_q[`WDPD_PER_HI:`WDPD_PER_LO] <=
					i_io_wdata[`WDPD_PER_HI:`WDPD_PER_LO];
				if (i_io_wdata[`WDPD_BIT_EN])
					master_q[`WDPD_BIT_EN] <= 1'b1;
				if (key_halt_q)
					master_q[`WDPD_HALT_MODE_FIELD_HI:`WDPD_HALT_MODE_FIELD_LO] <=
						i_io_wdata[`WDPD_HALT_MODE_FIELD_HI:`WDPD_HALT_MODE_FIELD_LO];
				master_q[2:0] <= 3'h0;
				key_halt_q <= 1'b0;
				disarm_q <= ~i_io_wdata[`WDPD_BIT_EN];
			end
			else if (wr_cmd)
			begin
				key_halt_q <= (i_io_wdata == `WDPD_KEY_HALT_MODE_FIELD);
				disarm_q <= 1'b0;
			end
			// Pending disable: enable bit clear was requested by last master write
			if (wr_cmd && (i_io_wdata == `WDPD_KEY_DISABLE) && disarm_q)
				master_q[`WDPD_BIT_EN] <= 1'b0;
		end
	end

	// Misc control register
	always @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
			misc_q <= `WDPD_MISC_RESET;
		else if (wr_misc)
			misc_q <= {4'h0, i_io_wdata[3:0]};
	end

	// Halt state machine
	always @*
	begin
		st_d = st_q;
		case (st_q)
			ST_RUN:
				if (i_halt_t4)
					st_d = ST_HALT;
			ST_HALT:
				if (!rst_n_s)
					st_d = ST_RUN;
				else if (halt_mode != `WDPD_HALT_MODE_FIELD_RUN && i_clk_from_gen)
					st_d = ST_STOPPED;
				else if (i_int_ack)
					st_d = ST_RUN;
			ST_STOPPED:
				if (!rst_n_s)
					st_d = ST_RUN;
				else if (wake)
					st_d = ST_NOP;
			ST_NOP:
				if (!rst_n_s)
					st_d = ST_RUN;
				else if (i_nop_t4)
					st_d = i_int_ack ? ST_RUN : ST_STOPPED;
			default:
				st_d = ST_RUN;
		endcase
	end

	always @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
			st_q <= ST_RUN;
		else
			st_q <= st_d;
	end

	assign clocks_off = (st_q == ST_STOPPED);

	// Clock gates per mode
	always @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_cpu_clk_en <= 1'b1;
			o_ctr_clk_en <= 1'b1;
			o_osc_run <= 1'b1;
		end
		else
		begin
			o_cpu_clk_en <= ~(st_d == ST_STOPPED);
			o_ctr_clk_en <= ~(st_d == ST_STOPPED && halt_mode != `WDPD_HALT_MODE_FIELD_SECOND_IDLE_MODE);
			o_osc_run <= ~(st_d == ST_STOPPED && halt_mode == `WDPD_HALT_MODE_FIELD_STOP);
		end
	end

	// Divide-by-two generator, held low when its output must stop
	always @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			div_q <= 1'b0;
			o_generator_clock_output <= 1'b0;
		end
		else
		begin
			div_q <= osc_s;
			if (clocks_off && halt_mode != `WDPD_HALT_MODE_FIELD_SECOND_IDLE_MODE)
				o_generator_clock_output <= 1'b0;
			else if (osc_s && !div_q)
				o_generator_clock_output <= ~o_generator_clock_output;
		end
	end

	// Period select, longer codes give longer timeouts
	always @*
	begin
		case (master_q[`WDPD_PER_HI:`WDPD_PER_LO])
			2'b00: limit = {CNT_W{1'b1}} >> `WDPD_PER0_SHIFT;
			2'b01: limit = {CNT_W{1'b1}} >> `WDPD_PER1_SHIFT;
			2'b10: limit = {CNT_W{1'b1}} >> `WDPD_PER2_SHIFT;
			default: limit = {CNT_W{1'b1}};
		endcase
	end

	assign expire = wdt_en && (cnt_q == limit);
	assign tout_active = (pulse_q != 3'd0);

	// Watchdog counter and timeout output
	always @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			cnt_q <= {CNT_W{1'b0}};
			pulse_q <= 3'd0;
			o_timeout_output_n <= 1'b1;
		end
		else
		begin
			if (wr_cmd && i_io_wdata == `WDPD_KEY_CLEAR && !(expire && !clocks_off)) // Set wins
			begin
				cnt_q <= {CNT_W{1'b0}};
				pulse_q <= 3'd0;
				o_timeout_output_n <= 1'b1;
			end
			else if (!wdt_en)
				cnt_q <= {CNT_W{1'b0}};
			else if (!clocks_off)
			begin
				if (expire)
				begin
					cnt_q <= {CNT_W{1'b0}};
					o_timeout_output_n <= 1'b0;
					pulse_q <= 3'd`WDPD_TIMEOUT_PULSE;
				end
				else
					cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
				if (!expire && tout_active && i_tout_to_reset)
				begin
					pulse_q <= pulse_q - 3'd1;
					if (pulse_q == 3'd1)
						o_timeout_output_n <= 1'b1;
				end
			end
			// Without reset wiring the level holds until clear
		end
	end

	// Reset output drive after reset ends a halt
	always @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			rst_n_prev_q <= 1'b1;
			rst_cnt_q <= 5'd0;
			o_reset_out_n <= 1'b1;
			o_reset_out_oe <= 1'b0;
		end
		else
		begin
			rst_n_prev_q <= rst_n_s;
			if (rst_n_prev_q && !rst_n_s && st_q != ST_RUN
				&& !misc_q[`WDPD_BIT_RSTOUT_DIS])
				rst_cnt_q <= 5'd`WDPD_RSTOUT_CYCLES;
			else if (rst_cnt_q != 5'd0)
				rst_cnt_q <= rst_cnt_q - 5'd1;
			o_reset_out_n <= ~(rst_cnt_q != 5'd0);
			o_reset_out_oe <= (rst_cnt_q != 5'd0);
		end
	end

	// Chip selects and CRC select
	always @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_chip_select_first_n <= 1'b1;
			o_chip_select_second_n <= 1'b1;
			o_crc32_sel <= 1'b0;
		end
		else
		begin
			o_crc32_sel <= misc_q[`WDPD_BIT_CRC32];
			o_chip_select_first_n <= ~(misc_q[`WDPD_BIT_CS0_EN]
				&& cs_hit(i_addr_hi, i_cs0_base, i_cs0_limit));
			o_chip_select_second_n <= ~(misc_q[`WDPD_BIT_CS1_EN]
				&& cs_hit(i_addr_hi, i_cs1_base, i_cs1_limit));
		end
	end

	// Read data
	always @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
			o_io_rdata <= 8'h00;
		else if (i_io_rd)
		begin
			case (i_io_addr)
				`WDPD_ADDR_MASTER: o_io_rdata <= master_q;
				`WDPD_ADDR_MISC: o_io_rdata <= misc_q;
				default: o_io_rdata <= 8'h00;
			endcase
		end
	end
endmodule

// File: sim/wdpd_props.sv
// Assertions on the watchdog, halt and chip-select ports.
// Assumes binding to wdpd_top; one clock, async reset.
`timescale 1ns/100ps
module wdpd_props #(
	parameter CNT_W = 24
)
(
	input wire i_core_clk, // Clock
	input wire i_rst, // Reset
	input wire i_io_wr, // Write strobe
	input wire i_halt_t4, // Halt fetch
	input wire i_nop_t4, // Restart fetch
	input wire i_int_n_pin, // Int pin
	input wire i_tout_to_reset, // Strap
	input wire [15:12] i_addr_hi, // Address
	input wire [3:0] i_cs0_base, // Range
	input wire [3:0] i_cs0_limit, // Range
	input wire [3:0] i_cs1_base, // Range
	input wire [3:0] i_cs1_limit, // Range
	input wire o_timeout_output_n, // Timeout
	input wire o_reset_out_n, // Reset drive
	input wire o_reset_out_oe, // Reset enable
	input wire o_osc_run, // Gate
	input wire o_cpu_clk_en, // Gate
	input wire o_ctr_clk_en, // Gate
	input wire o_crc32_sel, // CRC select
	input wire o_chip_select_first_n, // Select
	input wire o_chip_select_second_n // Select
);
	reg [4:0] oe_cnt_q;
	reg [2:0] since_q;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	// Reset drive length and age of last fetch pulse
	always @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			oe_cnt_q <= 5'h00;
			since_q <= 3'h7;
		end
		else
		begin
			oe_cnt_q <= o_reset_out_oe ? oe_cnt_q + 5'h01 : 5'h00;
			if (i_halt_t4 | i_nop_t4)
				since_q <= 3'h0;
			else if (since_q != 3'h7)
				since_q <= since_q + 3'h1;
		end
	end
	rst_state_a: assert property ($fell(i_rst) |-> o_timeout_output_n && o_cpu_clk_en
		&& o_chip_select_second_n && !o_crc32_sel) else $error("bad reset state");
	cs0_off_a: assert property ((i_addr_hi < i_cs0_base || i_addr_hi > i_cs0_limit)
		|=> o_chip_select_first_n) else $error("cs0 outside range");
	cs1_off_a: assert property ((i_addr_hi < i_cs1_base || i_addr_hi > i_cs1_limit)
		|=> o_chip_select_second_n) else $error("cs1 outside range");
	pulse_five_a: assert property ($fell(o_timeout_output_n) && i_tout_to_reset
		|-> !o_timeout_output_n [*5] ##1 o_timeout_output_n) else $error("pulse length");
	hold_low_a: assert property (!o_timeout_output_n && !i_tout_to_reset && !i_io_wr
		|=> !o_timeout_output_n) else $error("timeout released");
	rstout_len_a: assert property ($fell(o_reset_out_oe) |-> oe_cnt_q == 5'd16)
		else $error("reset drive length");
	rstout_low_a: assert property (o_reset_out_oe |-> !o_reset_out_n)
		else $error("reset drive level");
	stop_all_a: assert property (!o_osc_run |-> !o_cpu_clk_en && !o_ctr_clk_en)
		else $error("stop gates");
	halt_cause_a: assert property ($fell(o_cpu_clk_en) |-> since_q < 3'h6)
		else $error("clock stop without halt");
	wake_int_a: assert property ($fell(i_int_n_pin) && !o_cpu_clk_en
		|-> ##[1:8] o_cpu_clk_en) else $error("no wake");
	freeze_a: assert property ($fell(o_timeout_output_n) |-> $past(o_cpu_clk_en))
		else $error("count ran while stopped");
	c_tout: cover property ($fell(o_timeout_output_n));
	c_rstout: cover property ($rose(o_reset_out_oe));
	c_stop: cover property (!o_osc_run);
endmodule
bind wdpd_top wdpd_props #(.CNT_W(CNT_W)) u_props (.*);

// File: sim/wdpd_pin_model.sv
// Far-side pins: reset button, wake sources and timeout wiring.
// Assumes request levels from the bench; pins pulled up.
`timescale 1ns/100ps
module wdpd_pin_model
(
	input wire i_timeout_n, // Watchdog output
	input wire i_wired, // Timeout tied to reset
	input wire i_rst_req, // Button reset
	input wire i_nmi_req, // NMI source
	input wire i_int_req, // INT source
	output wire o_reset_n, // Reset pin
	output wire o_nmi_n, // NMI pin
	output wire o_int_n // INT pin
);
	// Open-drain pins idle high
	assign o_reset_n = !i_rst_req && (i_timeout_n || !i_wired);
	assign o_nmi_n = !i_nmi_req;
	assign o_int_n = !i_int_req;
endmodule

// File: sim/wdpd_top_tb.sv
// Self-checking bench for the watchdog and power-down block.
// Assumes the pin model on the far side and a 200 MHz clock.
`timescale 1ns/100ps
`include "wdpd_defs.vh"
module wdpd_top_tb;
	reg i_core_clk = 1'b0, i_rst = 1'b1, i_io_wr = 1'b0, i_io_rd = 1'b0, i_halt_t4 = 1'b0;
	reg i_nop_t4 = 1'b0, i_int_ack = 1'b0, i_tout_to_reset = 1'b0, i_clk_from_gen = 1'b1;
	reg i_osc_in = 1'b0, rst_req = 1'b0, nmi_req = 1'b0, int_req = 1'b0, chk_q = 1'b0;
	reg [7:0] i_io_addr = 8'h00, i_io_wdata = 8'h00, r = 8'h00;
	reg [15:12] i_addr_hi = 4'h0;
	reg [3:0] i_cs0_base = 4'h0, i_cs0_limit = 4'h0, i_cs1_base = 4'h0, i_cs1_limit = 4'h0;
	wire i_reset_n_pin, i_nmi_n_pin, i_int_n_pin, o_timeout_output_n, o_reset_out_n;
	wire o_reset_out_oe, o_generator_clock_output, o_osc_run, o_cpu_clk_en, o_ctr_clk_en;
	wire o_crc32_sel, o_chip_select_first_n, o_chip_select_second_n;
	wire [7:0] o_io_rdata;
	wire [7:0] gates = {5'h00, o_osc_run, o_ctr_clk_en, o_cpu_clk_en};
	integer miscompares = 0, n_tests = 0, i, k, n;
	localparam integer TB_CNT_W = 12;
	localparam integer PERIOD0 = 1 << (TB_CNT_W - `WDPD_PER0_SHIFT);
	integer osc_rises = 0;
	reg [7:0] exp_q[$];
	wdpd_top #(.CNT_W(TB_CNT_W)) DUT (.*);
	wdpd_pin_model u_pins (.i_timeout_n(o_timeout_output_n), .i_wired(i_tout_to_reset),
		.i_rst_req(rst_req), .i_nmi_req(nmi_req), .i_int_req(int_req),
		.o_reset_n(i_reset_n_pin), .o_nmi_n(i_nmi_n_pin), .o_int_n(i_int_n_pin));
	// Core clock and unrelated oscillator
	always #2.5 i_core_clk = ~i_core_clk;
	always #13.3 i_osc_in = ~i_osc_in;
	always @(posedge i_osc_in) osc_rises = osc_rises + 1;
	task check(input string nm, input [7:0] seen, input [7:0] exp);
	begin
		n_tests = n_tests + 1;
		if (seen !== exp)
		begin
			miscompares = miscompares + 1;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	end
	endtask
	task report_and_stop;
	begin
		if (miscompares == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask
	task tick(input integer c);
	begin
		repeat (c) @(posedge i_core_clk);
		#1;
	end
	endtask
	task io_wr(input [7:0] a, input [7:0] d);
	begin
		i_io_wr = 1'b1;
		i_io_addr = a;
		i_io_wdata = d;
		tick(1);
		i_io_wr = 1'b0;
		tick(1);
	end
	endtask
	task io_rd(input [7:0] a, input [7:0] e);
	begin
		exp_q.push_back(e);
		i_io_rd = 1'b1;
		i_io_addr = a;
		tick(1);
		i_io_rd = 1'b0;
		tick(1);
	end
	endtask
	task pulse(input nop, input ack);
	begin
		i_int_ack = ack;
		i_nop_t4 = nop;
		i_halt_t4 = !nop;
		tick(1);
		i_nop_t4 = 1'b0;
		i_halt_t4 = 1'b0;
		tick(5);
		i_int_ack = 1'b0;
	end
	endtask
	task wake(input use_nmi);
	begin
		nmi_req = use_nmi;
		int_req = !use_nmi;
		tick(6);
		nmi_req = 1'b0;
		int_req = 1'b0;
		tick(1);
	end
	endtask
	// Read monitor: oldest expected value against returned data
	always @(posedge i_core_clk)
	begin
		if (chk_q)
			check("rdata", o_io_rdata, exp_q.pop_front());
		chk_q <= i_io_rd;
	end
	// Main sequence
	initial
	begin
		void'($urandom(32'h68c9a88a));
		tick(8);
		i_rst = 1'b0;
		io_rd(`WDPD_ADDR_MASTER, 8'hf8);
		io_rd(`WDPD_ADDR_MISC, 8'h01);
		io_rd(`WDPD_ADDR_CMD, 8'h00);
		io_rd(8'h3c, 8'h00);
		io_wr(8'hf0, 8'h80);
		io_rd(8'hf0, 8'h98);
		io_wr(8'hf1, `WDPD_KEY_HALT_MODE_FIELD);
		io_wr(8'hf0, 8'he8);
		io_rd(8'hf0, 8'he8);
		io_wr(8'hf0, 8'h68);
		io_rd(8'hf0, 8'he8);
		io_wr(8'hf1, `WDPD_KEY_DISABLE);
		io_rd(8'hf0, 8'h68);
		io_wr(8'hf0, 8'he8);
		io_rd(8'hf0, 8'he8);
		for (i = 0; i < 8; i = i + 1)
		begin
			r = $urandom & 8'h0f;
			{i_addr_hi, i_cs0_base, i_cs0_limit, i_cs1_base, i_cs1_limit} = 20'($urandom);
			i_cs0_limit = i_cs0_limit | i_cs0_base;
			i_cs1_limit = i_cs1_limit | i_cs1_base;
			io_wr(8'hf2, r);
			io_rd(8'hf2, r);
			check("crc", o_crc32_sel, r[2]);
			check("cs0", o_chip_select_first_n,
				!(r[0] && i_addr_hi >= i_cs0_base && i_addr_hi <= i_cs0_limit));
			check("cs1", o_chip_select_second_n,
				!(r[1] && i_addr_hi >= i_cs1_base && i_addr_hi <= i_cs1_limit));
		end
		io_wr(8'hf2, 8'h01);
		for (i = 0; i < 5; i = i + 1)
		begin
			i_clk_from_gen = (i != 4);
			io_wr(8'hf1, `WDPD_KEY_HALT_MODE_FIELD);
			io_wr(8'hf0, {3'b111, i[1:0], 3'b000});
			check("gates", gates, 8'h07);
			pulse(1'b0, 1'b0);
			n = (i > 2) ? 7 : (i == 0) ? 4 : (i == 1) ? 6 : 0;
			check("gates", gates, n[7:0]);
			if (i == 0 || i == 2)
				check("generator_clock_output", o_generator_clock_output, 1'b0);
			if (i == 2)
			begin
				rst_req = 1'b1;
				n = 0;
				for (k = 0; k < 40; k = k + 1)
				begin
					tick(1);
					n = n + o_reset_out_oe;
					if (k == 2)
						rst_req = 1'b0;
				end
				check("rstout", n[7:0], 8'h10);
			end
			else
			begin
				wake(i[0]);
				check("wake", o_cpu_clk_en, 1'b1);
				if (i < 2)
				begin
					pulse(1'b1, 1'b0);
					check("reidle", o_cpu_clk_en, 1'b0);
					wake(i[0]);
				end
			end
			pulse(1'b1, 1'b1);
			check("run", o_cpu_clk_en, 1'b1);
		end
		i_clk_from_gen = 1'b1;
		// Generator output toggles once per oscillator rise
		n = osc_rises;
		k = 0;
		for (i = 0; i < 100; i = i + 1)
		begin
			r[0] = o_generator_clock_output;
			tick(1);
			k = k + (o_generator_clock_output != r[0]);
		end
		n = osc_rises - n - k;
		check("clkdiv", (n >= -1 && n <= 1), 1'b1);
		io_wr(8'hf1, `WDPD_KEY_HALT_MODE_FIELD);
		io_wr(8'hf0, 8'h98);
		io_wr(8'hf1, `WDPD_KEY_CLEAR);
		n = 0;
		while (o_timeout_output_n !== 1'b0 && n < 4 * PERIOD0)
		begin
			tick(1);
			n = n + 1;
		end
		check("period", n[7:0], 8'(PERIOD0 - 1));
		if (n >= 4 * PERIOD0)
			report_and_stop;
		tick(20);
		check("hold", o_timeout_output_n, 1'b0);
		io_wr(8'hf1, `WDPD_KEY_CLEAR);
		check("clear", o_timeout_output_n, 1'b1);
		// Timeout wired to reset: the low level lasts five clocks
		i_tout_to_reset = 1'b1;
		io_wr(8'hf1, `WDPD_KEY_CLEAR);
		n = 0;
		while (o_timeout_output_n !== 1'b0 && n < 4 * PERIOD0)
		begin
			tick(1);
			n = n + 1;
		end
		k = 0;
		for (i = 0; i < 8; i = i + 1)
		begin
			k = k + !o_timeout_output_n;
			tick(1);
		end
		check("pulse", k[7:0], 8'h05);
		report_and_stop;
	end
endmodule
